// [common/cal_host_consts.vh]
`ifndef CAL_HOST_CONSTS_VH
`define CAL_HOST_CONSTS_VH

// ---------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ---------------------------------------------------------------
`define OFS_CTRL          12'h000
`define OFS_CFG           12'h004
`define OFS_CMD           12'h008
`define OFS_STATUS        12'h00C
`define OFS_RESULT        12'h010

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTRL_GO_BIT       0
`define CFG_MODE_LSB      8
`define CFG_RESET         10'h028
`define ST_BUSY_BIT       0
`define ST_DONE_BIT       1
`define ST_NACK_BIT       2
`define ST_REFUSED_BIT    3
`define ST_MODEERR_BIT    4

// ---------------------------------------------------------------
// Wait modes after a command
// ---------------------------------------------------------------
`define WM_READY          2'h0
`define WM_POLL           2'h1
`define WM_TIMED          2'h2

// ---------------------------------------------------------------
// Command encodings and response byte
// ---------------------------------------------------------------
`define CMD_READ_LAST     8'h1F
`define CMD_WRITE_FIRST   8'h40
`define CMD_WRITE_LAST    8'h5F
`define CMD_RESUME_NORMAL 8'h80
`define CMD_ENTER_CAL     8'hA0
`define CMD_GET_REVISION  8'hB0
`define RESP_MODE_CMD     2'h2
`define RESP_BUSY         2'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS     5
`define T_SHORT_NS        100000
`define T_LONG_NS         12000000
`define WAIT_MUL          11
`define WAIT_DIV          10
`define QTR_DEFAULT       500
`define POLL_GAP_DEFAULT  2000

`endif

// [design/cal_cmd_host.v]
`timescale 1ns/1ps
// Functional notes
// - Enter-calibration only valid in power-on window
// - Commands travel only over I2C
// - Four bytes: address+W, command, 16-bit data
// - Host pads unused data field with zeros; code sends data_r as written for every command
// - 00-1F read word, ~100us, then fetch
// - Host waits 1.1 times typical times
// - Diagnostics checked regardless of response code
// - One command at a time, wait execution
// - End fetch after response for other commands
// - Corrected error word may be rewritten
// - Without ready, poll until not busy
// - Host sends only defined command encodings
`include "cal_host_consts.vh"
module cal_cmd_host #(
    parameter        QTR_CYCLES = `QTR_DEFAULT,
    parameter        SHORT_WAIT = (`T_SHORT_NS * `WAIT_MUL) / (`WAIT_DIV * `CLK_PERIOD_NS),
    parameter        LONG_WAIT  = (`T_LONG_NS * `WAIT_MUL) / (`WAIT_DIV * `CLK_PERIOD_NS),
    parameter        POLL_GAP   = `POLL_GAP_DEFAULT
) (
    input  wire        CLK_I,
    input  wire        RESET_I,
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [11:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output wire [31:0] PRDATA_O,
    output wire        PREADY_O,
    output wire        PSLVERR_O,
    input  wire        SCL_I,
    output wire        SCL_O,
    output wire        SCL_OE_O,
    input  wire        SDA_I,
    output wire        SDA_O,
    output wire        SDA_OE_O,
    input  wire        READY_I
);

// ---------------------------------------------------------------
// State codes
// ---------------------------------------------------------------
localparam L_IDLE  = 2'h0;
localparam L_START = 2'h1;
localparam L_BIT   = 2'h2;
localparam L_STOP  = 2'h3;
localparam H_IDLE  = 3'h0;
localparam H_CMD   = 3'h1;
localparam H_WAIT  = 3'h2;
localparam H_FETCH = 3'h3;
localparam H_GAP   = 3'h4;

// ---------------------------------------------------------------
// Command decoding
// ---------------------------------------------------------------
function cmd_valid;
    input [7:0] c;
    begin
        cmd_valid = (c <= `CMD_READ_LAST) ||
                    (c >= `CMD_WRITE_FIRST && c <= `CMD_WRITE_LAST) ||
                    (c == `CMD_RESUME_NORMAL) || (c == `CMD_ENTER_CAL) ||
                    (c == `CMD_GET_REVISION);
    end
endfunction

// Bytes that follow the response byte in a fetch
function [1:0] cmd_extra;
    input [7:0] c;
    begin
        if (c <= `CMD_READ_LAST)
            cmd_extra = 2'h2;
        else if (c == `CMD_GET_REVISION)
            cmd_extra = 2'h1;
        else
            cmd_extra = 2'h0;
    end
endfunction

// ---------------------------------------------------------------
// Synchronisers
// ---------------------------------------------------------------
reg  [1:0]  scl_s_r;
reg  [1:0]  sda_s_r;
reg  [2:0]  rdy_s_r;
wire        scl_in  = scl_s_r[1];
wire        sda_in  = sda_s_r[1];
wire        rdy_rise = rdy_s_r[1] & ~rdy_s_r[2];

always @(posedge CLK_I) begin
    if (RESET_I) begin
        scl_s_r <= 2'h3;
        sda_s_r <= 2'h3;
        rdy_s_r <= 3'h7;
    end else begin
        scl_s_r <= {scl_s_r[0], SCL_I};
        sda_s_r <= {sda_s_r[0], SDA_I};
        rdy_s_r <= {rdy_s_r[1:0], READY_I};
    end
end

// ---------------------------------------------------------------
// Registers and state
// ---------------------------------------------------------------
reg  [1:0]  ln_st_r;
reg  [1:0]  ph_r;
reg  [3:0]  bitn_r;
reg  [1:0]  idx_r;
reg  [8:0]  tx_r;
reg  [8:0]  rx_r;
reg         scl_drv_r;
reg         sda_drv_r;
reg         ln_nack_r;
reg         ln_done_r;
reg         ln_go_r;
reg  [15:0] qcnt_r;
reg  [7:0]  rbuf_r [0:3];
reg  [2:0]  h_st_r;
reg         rd_r;
reg  [1:0]  last_r;
reg  [7:0]  cmd_r;
reg  [15:0] data_r;
reg  [9:0]  cfg_r;
reg  [21:0] wcnt_r;
reg         rdy_seen_r;
reg         done_r;
reg         nack_r;
reg         refused_r;
reg         modeerr_r;
reg  [23:0] result_r;
reg  [31:0] prdata_r;

wire        tick = (qcnt_r == QTR_CYCLES - 1);
wire [1:0]  mode = cfg_r[`CFG_MODE_LSB+1:`CFG_MODE_LSB];
wire [7:0]  resp = rbuf_r[1];

// ---------------------------------------------------------------
// APB slave, zero wait states
// ---------------------------------------------------------------
wire mapped = (PADDR_I == `OFS_CTRL) || (PADDR_I == `OFS_CFG) ||
              (PADDR_I == `OFS_CMD) || (PADDR_I == `OFS_STATUS) ||
              (PADDR_I == `OFS_RESULT);
wire wr_acc = PSEL_I & PENABLE_I & PWRITE_I & mapped;
wire idle   = (h_st_r == H_IDLE);
wire go     = wr_acc & (PADDR_I == `OFS_CTRL) & PWDATA_I[`CTRL_GO_BIT] & idle;
wire [31:0] status = {18'h0, resp[5:2], resp[1:0], 3'h0, modeerr_r,
                      refused_r, nack_r, done_r, ~idle};

assign PREADY_O  = 1'b1;
assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
assign PRDATA_O  = prdata_r;

always @(posedge CLK_I) begin
    if (RESET_I) begin
        prdata_r <= 32'h0;
    end else if (PSEL_I & ~PENABLE_I) begin
        case (PADDR_I)
            `OFS_CFG:    prdata_r <= {22'h0, cfg_r};
            `OFS_CMD:    prdata_r <= {8'h0, data_r, cmd_r};
            `OFS_STATUS: prdata_r <= status;
            `OFS_RESULT: prdata_r <= {8'h0, result_r};
            default:     prdata_r <= 32'h0;
        endcase
    end
end

// Config and command are frozen while a sequence runs
always @(posedge CLK_I) begin
    if (RESET_I) begin
        cfg_r  <= `CFG_RESET;
        cmd_r  <= 8'h0;
        data_r <= 16'h0;
    end else if (wr_acc & idle) begin
        if (PADDR_I == `OFS_CFG)
            cfg_r <= PWDATA_I[9:0];
        if (PADDR_I == `OFS_CMD) begin
            cmd_r  <= PWDATA_I[7:0];
            data_r <= PWDATA_I[23:8];
        end
    end
end

// ---------------------------------------------------------------
// I2C byte engine (open drain, honours clock stretching)
// ---------------------------------------------------------------
reg  [8:0] cur_tx;
always @* begin
    if (idx_r == 2'h0)
        cur_tx = {cfg_r[6:0], rd_r, 1'b1};
    else if (rd_r)
        cur_tx = {8'hFF, idx_r == last_r};
    else if (idx_r == 2'h1)
        cur_tx = {cmd_r, 1'b1};
    else if (idx_r == 2'h2)
        cur_tx = {data_r[15:8], 1'b1};
    else
        cur_tx = {data_r[7:0], 1'b1};
end

assign SCL_O    = 1'b0;
assign SDA_O    = 1'b0;
assign SCL_OE_O = scl_drv_r;
assign SDA_OE_O = sda_drv_r;

always @(posedge CLK_I) begin
    if (RESET_I) begin
        qcnt_r <= 16'h0;
    end else if (ln_st_r == L_IDLE || tick) begin
        qcnt_r <= 16'h0;
    end else begin
        qcnt_r <= qcnt_r + 16'h1;
    end
end

always @(posedge CLK_I) begin
    if (RESET_I) begin
        ln_st_r   <= L_IDLE;
        ph_r      <= 2'h0;
        bitn_r    <= 4'h0;
        idx_r     <= 2'h0;
        tx_r      <= 9'h1FF;
        rx_r      <= 9'h0;
        scl_drv_r <= 1'b0;
        sda_drv_r <= 1'b0;
        ln_nack_r <= 1'b0;
        ln_done_r <= 1'b0;
        rbuf_r[0] <= 8'h0;
        rbuf_r[1] <= 8'h0;
        rbuf_r[2] <= 8'h0;
        rbuf_r[3] <= 8'h0;
    end else begin
        ln_done_r <= 1'b0;
        case (ln_st_r)
            L_IDLE: begin
                if (ln_go_r) begin
                    ln_st_r   <= L_START;
                    ph_r      <= 2'h0;
                    idx_r     <= 2'h0;
                    ln_nack_r <= 1'b0;
                end
            end
            L_START: begin
                if (tick) begin
                    case (ph_r)
                        2'h0: begin
                            scl_drv_r <= 1'b0;
                            sda_drv_r <= 1'b0;
                            ph_r      <= 2'h1;
                        end
                        2'h1: begin
                            if (scl_in) begin
                                sda_drv_r <= 1'b1;
                                ph_r      <= 2'h2;
                            end
                        end
                        default: begin
                            scl_drv_r <= 1'b1;
                            ph_r      <= 2'h0;
                            bitn_r    <= 4'h0;
                            ln_st_r   <= L_BIT;
                        end
                    endcase
                end
            end
            L_BIT: begin
                if (tick) begin
                    case (ph_r)
                        2'h0: begin
                            if (bitn_r == 4'h0) begin
                                sda_drv_r <= ~cur_tx[8];
                                tx_r      <= {cur_tx[7:0], 1'b1};
                            end else begin
                                sda_drv_r <= ~tx_r[8];
                                tx_r      <= {tx_r[7:0], 1'b1};
                            end
                            ph_r <= 2'h1;
                        end
                        2'h1: begin
                            scl_drv_r <= 1'b0;
                            ph_r      <= 2'h2;
                        end
                        2'h2: begin
                            if (scl_in) begin
                                rx_r <= {rx_r[7:0], sda_in};
                                ph_r <= 2'h3;
                            end
                        end
                        default: begin
                            scl_drv_r <= 1'b1;
                            ph_r      <= 2'h0;
                            if (bitn_r == 4'h8) begin
                                bitn_r        <= 4'h0;
                                rbuf_r[idx_r] <= rx_r[8:1];
                                if ((!rd_r || idx_r == 2'h0) && rx_r[0]) begin
                                    ln_nack_r <= 1'b1;
                                    ln_st_r   <= L_STOP;
                                end else if (idx_r == last_r) begin
                                    ln_st_r <= L_STOP;
                                end else begin
                                    idx_r <= idx_r + 2'h1;
                                end
                            end else begin
                                bitn_r <= bitn_r + 4'h1;
                            end
                        end
                    endcase
                end
            end
            default: begin
                if (tick) begin
                    case (ph_r)
                        2'h0: begin
                            scl_drv_r <= 1'b1;
                            sda_drv_r <= 1'b1;
                            ph_r      <= 2'h1;
                        end
                        2'h1: begin
                            scl_drv_r <= 1'b0;
                            if (scl_in)
                                ph_r <= 2'h2;
                        end
                        default: begin
                            sda_drv_r <= 1'b0;
                            ph_r      <= 2'h0;
                            ln_done_r <= 1'b1;
                            ln_st_r   <= L_IDLE;
                        end
                    endcase
                end
            end
        endcase
    end
end

// ---------------------------------------------------------------
// Command sequencer
// ---------------------------------------------------------------
always @(posedge CLK_I) begin
    if (RESET_I) begin
        h_st_r     <= H_IDLE;
        ln_go_r    <= 1'b0;
        rd_r       <= 1'b0;
        last_r     <= 2'h3;
        wcnt_r     <= 22'h0;
        rdy_seen_r <= 1'b0;
        done_r     <= 1'b0;
        nack_r     <= 1'b0;
        refused_r  <= 1'b0;
        modeerr_r  <= 1'b0;
        result_r   <= 24'h0;
    end else begin
        ln_go_r <= 1'b0;
        if (rdy_rise && (h_st_r == H_CMD || h_st_r == H_WAIT))
            rdy_seen_r <= 1'b1;
        case (h_st_r)
            H_IDLE: begin
                if (go) begin
                    done_r    <= 1'b0;
                    nack_r    <= 1'b0;
                    modeerr_r <= 1'b0;
                    if (cmd_valid(cmd_r)) begin
                        refused_r  <= 1'b0;
                        rd_r       <= 1'b0;
                        last_r     <= 2'h3;
                        rdy_seen_r <= 1'b0;
                        ln_go_r    <= 1'b1;
                        h_st_r     <= H_CMD;
                    end else begin
                        refused_r <= 1'b1;
                        done_r    <= 1'b1;
                    end
                end
            end
            H_CMD: begin
                if (ln_done_r) begin
                    if (ln_nack_r) begin
                        nack_r <= 1'b1;
                        done_r <= 1'b1;
                        h_st_r <= H_IDLE;
                    end else if (cmd_r == `CMD_RESUME_NORMAL) begin
                        done_r <= 1'b1;
                        h_st_r <= H_IDLE;
                    end else begin
                        if (cmd_r >= `CMD_WRITE_FIRST && cmd_r <= `CMD_WRITE_LAST)
                            wcnt_r <= LONG_WAIT[21:0];
                        else
                            wcnt_r <= SHORT_WAIT[21:0];
                        h_st_r <= H_WAIT;
                    end
                end
            end
            H_WAIT: begin
                // no new command before the fetch completes
                if (mode == `WM_POLL) begin
                    rd_r    <= 1'b1;
                    last_r  <= 2'h1;
                    ln_go_r <= 1'b1;
                    h_st_r  <= H_FETCH;
                end else if ((mode == `WM_READY) ? rdy_seen_r : (wcnt_r == 22'h0)) begin
                    rd_r    <= 1'b1;
                    last_r  <= 2'h1 + cmd_extra(cmd_r);
                    ln_go_r <= 1'b1;
                    h_st_r  <= H_FETCH;
                end else if (wcnt_r != 22'h0) begin
                    wcnt_r <= wcnt_r - 22'h1;
                end
            end
            H_FETCH: begin
                if (ln_done_r) begin
                    if (ln_nack_r) begin
                        nack_r <= 1'b1;
                        done_r <= 1'b1;
                        h_st_r <= H_IDLE;
                    end else if (resp[1:0] == `RESP_BUSY && mode == `WM_POLL) begin
                        wcnt_r <= POLL_GAP[21:0];
                        h_st_r <= H_GAP;
                    end else if (last_r == 2'h1 && cmd_extra(cmd_r) != 2'h0) begin
                        // Poll fetch saw completion; fetch again with data
                        last_r  <= 2'h1 + cmd_extra(cmd_r);
                        ln_go_r <= 1'b1;
                    end else begin
                        modeerr_r <= (resp[7:6] != `RESP_MODE_CMD);
                        result_r  <= {rbuf_r[2], rbuf_r[3], resp};
                        done_r    <= 1'b1;
                        h_st_r    <= H_IDLE;
                    end
                end
            end
            H_GAP: begin
                if (wcnt_r == 22'h0) begin
                    last_r  <= 2'h1;
                    ln_go_r <= 1'b1;
                    h_st_r  <= H_FETCH;
                end else begin
                    wcnt_r <= wcnt_r - 22'h1;
                end
            end
            default: h_st_r <= H_IDLE;
        endcase
    end
end

endmodule

// [verification/cal_cmd_host_assertions.sv]
`timescale 1ns/1ps
`include "cal_host_consts.vh"
module cal_cmd_host_assertions #(
    parameter QTR_CYCLES = 4
) (
    input wire        CLK_I,
    input wire        RESET_I,
    input wire        PSEL_I,
    input wire        PENABLE_I,
    input wire        PWRITE_I,
    input wire [11:0] PADDR_I,
    input wire [31:0] PRDATA_O,
    input wire        PREADY_O,
    input wire        PSLVERR_O,
    input wire        SCL_O,
    input wire        SCL_OE_O,
    input wire        SDA_O,
    input wire        SDA_OE_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RESET_I);
    // ----------
    // SCL phase counters
    // ----------
    reg  [15:0] lo_r;
    reg  [15:0] hi_r;
    wire        hole = !(PADDR_I == `OFS_CTRL || PADDR_I == `OFS_CFG || PADDR_I == `OFS_CMD
                      || PADDR_I == `OFS_STATUS || PADDR_I == `OFS_RESULT);
    // Saturate so a long idle line cannot wrap into a false short phase
    always @(posedge CLK_I) begin
        if (RESET_I) begin
            lo_r <= 16'h0000;
            hi_r <= 16'h0000;
        end else begin
            lo_r <= !SCL_OE_O ? 16'h0000 : (&lo_r ? lo_r : lo_r + 16'h0001);
            hi_r <= SCL_OE_O ? 16'h0000 : (&hi_r ? hi_r : hi_r + 16'h0001);
        end
    end
    sequence apb_access;
        PSEL_I && PENABLE_I;
    endsequence
    sequence apb_hole_read;
        apb_access ##0 (!PWRITE_I && hole);
    endsequence
    a_pready_high: assert property (PSEL_I |-> PREADY_O)
        else $error("pready low in a transfer");
    a_slverr_map: assert property (apb_access |-> PSLVERR_O == hole)
        else $error("pslverr disagrees with map");
    a_slverr_idle: assert property (!(PSEL_I && PENABLE_I) |-> !PSLVERR_O)
        else $error("pslverr outside access");
    a_hole_reads_zero: assert property (apb_hole_read |-> PRDATA_O == 32'h00000000)
        else $error("unmapped read not zero");
    a_open_drain: assert property (!SCL_O && !SDA_O)
        else $error("line driven high");
    a_reset_release: assert property ($fell(RESET_I) |-> !SCL_OE_O && !SDA_OE_O)
        else $error("bus held after reset");
    a_scl_low_time: assert property ($fell(SCL_OE_O) |-> lo_r >= QTR_CYCLES)
        else $error("scl low phase short");
    a_scl_high_time: assert property ($rose(SCL_OE_O) |-> hi_r >= QTR_CYCLES)
        else $error("scl high phase short");
endmodule
bind cal_cmd_host cal_cmd_host_assertions #(.QTR_CYCLES(QTR_CYCLES)) chk_u (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .SCL_O(SCL_O), .SCL_OE_O(SCL_OE_O), .SDA_O(SDA_O),
    .SDA_OE_O(SDA_OE_O)
);

// [verification/cal_dev_model.sv]
`timescale 1ns/1ps
module cal_dev_model #(
    parameter [6:0] DEV_ADDR = 7'h28,
    parameter [7:0] REV_CODE = 8'h3A, // Arbitrary value
    parameter       T_SHORT  = 400,
    parameter       T_LONG   = 2000
) (
    input  wire       scl_i,
    input  wire       sda_i,
    input  wire       lock_i,
    input  wire [3:0] diag_i,
    output reg        sda_oe_o,
    output reg        ready_o
);
    reg     [15:0] mem_r [0:31];
    reg     [7:0]  pkt_r [0:3];
    reg     [7:0]  sr_r, tx_r, c_r;
    reg     [15:0] out_r;
    reg     [1:0]  code_r = 2'h1;
    reg            rd_r = 1'h0;
    reg            normal_r = 1'h0;
    integer        bc = 0, bi = -1, n_sent = 0, i;
    event          exec_ev;
    wire    [7:0]  resp = {2'h2, diag_i, code_r};
    initial begin
        sda_oe_o = 1'h0;
        ready_o = 1'h1;
        for (i = 0; i < 32; i = i + 1)
            mem_r[i] = 16'hA5C3 ^ i[15:0];
    end
    always @(negedge sda_i)
        if (scl_i) begin
            bc = 0;
            bi = 0;
            n_sent = 0;
        end
    // Normal operation executes no write packet, late enter command too; packets are still acked and reads still answered
    always @(posedge sda_i)
        if (scl_i) begin
            if (bi == 4 && !rd_r && !normal_r)
                -> exec_ev;
            bi = -1;
        end
    always @(posedge scl_i)
        if (bi >= 0) begin
            if (bc < 8)
                sr_r = {sr_r[6:0], sda_i};
            else if (rd_r && bi > 0 && sda_i)
                bi = -1;
            bc = bc + 1;
        end
    // SDA only moves while SCL is low
    always @(negedge scl_i)
        if (bi >= 0) begin
            if (bc == 8) begin
                if (bi == 0)
                    rd_r = sr_r[0];
                if (bi == 0 && sr_r[7:1] != DEV_ADDR)
                    bi = -1;
                else if (!rd_r)
                    pkt_r[bi] = sr_r;
                sda_oe_o = bi == 0 || (bi > 0 && !rd_r);
            end else if (bc == 9) begin
                bc = 0;
                bi = bi + 1;
                tx_r = bi == 1 ? resp : bi == 2 ? out_r[15:8] : out_r[7:0];
                n_sent = n_sent + rd_r;
                sda_oe_o = rd_r && !tx_r[7];
            end else
                sda_oe_o = rd_r && bi > 0 && !tx_r[7 - bc];
        end
    always @(exec_ev) begin
        c_r = pkt_r[1];
        code_r = 2'h0;
        ready_o = 1'h0;
        normal_r = c_r == 8'h80;
        #(c_r[6] ? T_LONG : T_SHORT);
        code_r = 2'h1;
        if (c_r <= 8'h1F)
            out_r = mem_r[c_r[4:0]];
        else if (c_r[7:5] == 3'h2 && lock_i && c_r[4:0] < 5'h16)
            code_r = 2'h2;
        else if (c_r[7:5] == 3'h2)
            mem_r[c_r[4:0]] = {pkt_r[2], pkt_r[3]};
        else if (c_r == 8'hB0)
            out_r = {REV_CODE, 8'h00};
        else if (c_r != 8'h80 && c_r != 8'hA0)
            code_r = 2'h2;
        ready_o = 1'h1;
    end
endmodule

// [verification/tb_calibration_command_mode.sv]
`timescale 1ns/1ps
`include "cal_host_consts.vh"
module tb_calibration_command_mode;
    reg         clk = 1'h0;
    reg         rst = 1'h1;
    reg         psel = 1'h0;
    reg         pen = 1'h0;
    reg         pwr = 1'h0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg         lock = 1'h1;
    reg  [3:0]  diag = 4'h0;
    wire [31:0] prdata;
    wire        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, dev_oe, rdy;
    wire        scl = !scl_oe;
    wire        sda = !(sda_oe || dev_oe);
    reg  [31:0] q, st, res;
    reg         slv;
    integer     err_total = 0, n_tests = 0, cyc = 0, n_start = 0, k;
    cal_cmd_host #(.QTR_CYCLES(4), .SHORT_WAIT(88), .LONG_WAIT(440), .POLL_GAP(20)) dut_u (
        .CLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .SCL_I(scl), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda),
        .SDA_O(sda_o), .SDA_OE_O(sda_oe), .READY_I(rdy)
    );
    cal_dev_model dev_u (
        .scl_i(scl), .sda_i(sda), .lock_i(lock), .diag_i(diag), .sda_oe_o(dev_oe), .ready_o(rdy)
    );
    always #2.5 clk = !clk;
    always @(negedge sda)
        if (scl === 1'h1)
            n_start = n_start + 1;
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            err_total = err_total + 1;
            end_of_test;
        end
    end
    task end_of_test;
        begin
            if (err_total == 0 && n_tests > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task check(input [63:0] nm, input [31:0] e, input [31:0] g);
        begin
            n_tests = n_tests + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("wrong value %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk);
            psel <= 1'h1;
            pen <= 1'h0;
            pwr <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            pen <= 1'h1;
            @(posedge clk);
            while (pready !== 1'h1)
                @(posedge clk);
            q = prdata;
            slv = pslverr;
            psel <= 1'h0;
            pen <= 1'h0;
        end
    endtask
    task run(input [7:0] c, input [15:0] d, input [1:0] m, input [6:0] a);
        begin
            apb(1'h1, `OFS_CFG, {22'h0, m, 1'h0, a});
            apb(1'h1, `OFS_CMD, {8'h0, d, c});
            apb(1'h1, `OFS_CTRL, 32'h1);
            q = 32'h0;
            while (q[`ST_DONE_BIT] !== 1'h1)
                apb(1'h0, `OFS_STATUS, 32'h0);
            st = q;
            apb(1'h0, `OFS_RESULT, 32'h0);
            res = q;
        end
    endtask
    task t_regs;
        begin
            apb(1'h0, `OFS_CFG, 32'h0);
            check("cfg", {22'h0, `CFG_RESET}, q);
            apb(1'h0, `OFS_STATUS, 32'h0);
            check("status", 32'h0, 32'(q[1:0]));
            apb(1'h0, 12'h014, 32'h0);
            check("hole", 32'h0, q);
            check("slverr", 32'h1, 32'(slv));
        end
    endtask
    task t_write_read;
        begin
            run(8'h56, 16'hBEEF, `WM_READY, 7'h28);
            check("wr code", 32'h1, 32'(st[9:8]));
            check("wr bytes", 32'h1, dev_u.n_sent);
            run(8'h16, 16'h0, `WM_READY, 7'h28);
            check("rd word", 32'hBEEF, 32'(res[23:8]));
            check("rd resp", 32'h81, 32'(res[7:0]));
            check("rd bytes", 32'h3, dev_u.n_sent);
            check("mode err", 32'h0, 32'(st[`ST_MODEERR_BIT]));
        end
    endtask
    task t_locked;
        begin
            run(8'h45, 16'h1234, `WM_POLL, 7'h28);
            check("lk code", 32'h2, 32'(st[9:8]));
            run(8'h05, 16'h0, `WM_POLL, 7'h28);
            check("lk word", 32'hA5C6, 32'(res[23:8]));
            lock = 1'h0;
            run(8'h45, 16'h1234, `WM_POLL, 7'h28);
            check("ul word", 32'h1234, 32'(dev_u.mem_r[5]));
        end
    endtask
    task t_revision;
        begin
            diag = 4'h5;
            run(8'hB0, 16'h0, `WM_POLL, 7'h28);
            check("rv resp", 32'h95, 32'(res[7:0]));
            check("rv diag", 32'h5, 32'(st[13:10]));
            check("rv byte", 32'h3A, 32'(res[23:16]));
            check("rv bytes", 32'h2, dev_u.n_sent);
            diag = 4'h0;
        end
    endtask
    task t_timed;
        begin
            run(8'h1F, 16'h0, `WM_TIMED, 7'h28);
            check("tm word", 32'hA5DC, 32'(res[23:8]));
            run(8'h5F, 16'h0F0F, `WM_TIMED, 7'h28);
            check("tm code", 32'h1, 32'(st[9:8]));
        end
    endtask
    task t_codes;
        begin
            k = n_start;
            run(8'h22, 16'h0, `WM_READY, 7'h28);
            check("bad ref", 32'h1, 32'(st[`ST_REFUSED_BIT]));
            check("bad bus", k, n_start);
            run(8'hA0, 16'h0, `WM_READY, 7'h28);
            check("cm code", 32'h1, 32'(st[9:8]));
            run(8'h00, 16'h0, `WM_READY, 7'h29);
            check("nack", 32'h1, 32'(st[`ST_NACK_BIT]));
            run(8'h80, 16'h0, `WM_READY, 7'h28);
            check("resume", 32'h1, 32'(dev_u.normal_r));
            check("rs nack", 32'h0, 32'(st[`ST_NACK_BIT]));
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        t_regs;
        t_write_read;
        t_locked;
        t_revision;
        t_timed;
        t_codes;
        end_of_test;
    end
endmodule
